// File: logic_string_branch_decode.sv
// opcode decode and clock budget for logic, string and branch instructions
`timescale 1ns/100ps
`include "decode_timing_regs.svh"
module logic_string_branch_decode
	import decode_pkg::*;
#(
	parameter int COUNT_W  = 16,
	parameter int BUDGET_W = 24
) (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire logic                instr_valid,
	input  wire logic [7:0]          opcode_byte,
	input  wire logic [7:0]          modrm_byte,
	input  wire logic                prefix_valid,
	input  wire logic [7:0]          prefix_byte,
	input  wire logic [COUNT_W-1:0]  count_register,
	input  wire logic                narrow_bus,
	output logic                     dec_valid,
	output op_class_t                op_class,
	output logic                     word_op,
	output logic                     reg_is_dest,
	output logic                     repeat_active,
	output logic                     repeat_on_equal,
	output logic                     modrm_used,
	output logic [2:0]               imm_bytes,
	output logic [2:0]               disp_bytes,
	output logic [BUDGET_W-1:0]      cycle_budget,
	output logic                     unsupported
);

	initial begin
		if (COUNT_W < 1 || COUNT_W > 16) begin
			$error("count width must be 1 to 16");
		end
	end

	op_class_t           cls_nxt;
	logic [7:0]          base_nxt;
	logic [7:0]          iter_nxt;
	logic                rep_nxt;
	logic                unsup_nxt;
	logic                modrm_nxt;
	logic [2:0]          imm_nxt;
	logic [2:0]          disp_nxt;
	logic [BUDGET_W-1:0] budget_nxt;
	logic                w_bit;
	logic                mem_opnd;
	logic                rep_seen;
	logic                rep_z_form;
	logic [2:0]          ext;
	logic                star_word;

	assign w_bit      = opcode_byte[`FLD_W];
	assign ext        = modrm_byte[`FLD_REG_HI:`FLD_REG_LO];
	assign mem_opnd   = modrm_byte[`FLD_MOD_HI:`FLD_MOD_LO] != 2'h3;
	assign rep_seen   = prefix_valid && prefix_byte[7:1] == PAT_REPEAT;
	assign rep_z_form = prefix_byte != PAT_REPEAT_NZ;
	assign star_word  = narrow_bus && w_bit;

	// opcode classification and base clock cost
	always_comb begin
		cls_nxt   = OP_NONE;
		base_nxt  = 8'h00;
		iter_nxt  = 8'h00;
		rep_nxt   = 1'b0;
		unsup_nxt = 1'b0;
		modrm_nxt = 1'b0;
		imm_nxt   = 3'h0;
		disp_nxt  = 3'h0;
		if (opcode_byte[7:2] == PAT_XOR_RM) begin
			cls_nxt   = OP_XOR_RM;
			modrm_nxt = 1'b1;
			base_nxt  = mem_opnd ? `T_XOR_RM_MEM : `T_XOR_RM_REG;
		end else if (opcode_byte[7:1] == PAT_IMM_GROUP && ext == EXT_XOR) begin
			cls_nxt   = OP_XOR_IMM_RM;
			modrm_nxt = 1'b1;
			imm_nxt   = w_bit ? 3'h2 : 3'h1;
			base_nxt  = mem_opnd ? `T_XOR_IMM_MEM : `T_XOR_IMM_REG;
		end else if (opcode_byte[7:1] == PAT_XOR_ACC) begin
			cls_nxt   = OP_XOR_IMM_ACC;
			imm_nxt   = w_bit ? 3'h2 : 3'h1;
			base_nxt  = w_bit ? `T_XOR_ACC_WORD : `T_XOR_ACC_BYTE;
		end else if (opcode_byte[7:1] == PAT_UNARY_GROUP && ext == EXT_INVERT) begin
			cls_nxt   = OP_INVERT;
			modrm_nxt = 1'b1;
			base_nxt  = mem_opnd ? `T_INV_MEM : `T_INV_REG;
		end else if (opcode_byte[7:1] == PAT_STR_MOVE) begin
			cls_nxt  = STRING_MOVE_OP;
			base_nxt = rep_seen ? `T_REP_MOVE_BASE : `T_STR_MOVE;
			iter_nxt = `T_REP_MOVE_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte[7:1] == PAT_STR_CMP) begin
			cls_nxt  = STRING_COMPARE_OP;
			base_nxt = rep_seen ? `T_REP_CMP_BASE : `T_STR_CMP;
			iter_nxt = `T_REP_CMP_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte[7:1] == PAT_STR_SCAN) begin
			cls_nxt  = STRING_SCAN_OP;
			base_nxt = rep_seen ? `T_REP_SCAN_BASE : `T_STR_SCAN;
			iter_nxt = `T_REP_SCAN_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte[7:1] == PAT_STR_LOAD) begin
			cls_nxt  = STRING_LOAD_OP;
			base_nxt = rep_seen ? `T_REP_LOAD_BASE : `T_STR_LOAD;
			iter_nxt = `T_REP_LOAD_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte[7:1] == PAT_STR_STORE) begin
			cls_nxt  = STRING_STORE_OP;
			base_nxt = rep_seen ? `T_REP_STORE_BASE : `T_STR_STORE;
			iter_nxt = `T_REP_STORE_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte[7:1] == PAT_STR_IN || opcode_byte[7:1] == PAT_STR_OUT) begin
			cls_nxt  = opcode_byte[1] ? STRING_PORT_OUT_OP : STRING_PORT_IN_OP;
			base_nxt = rep_seen ? `T_REP_MOVE_BASE : `T_STR_PORT;
			iter_nxt = `T_REP_MOVE_ITER;
			rep_nxt  = rep_seen;
		end else if (opcode_byte == PAT_GROUP_FF) begin
			modrm_nxt = 1'b1;
			if (ext == EXT_CALL_NEAR) begin
				cls_nxt  = CALL_NEAR_IND_OP;
				if (narrow_bus) begin
					base_nxt = mem_opnd ? `T_CALL_NI_MEM_N : `T_CALL_NI_REG_N;
				end else begin
					base_nxt = mem_opnd ? `T_CALL_NI_MEM_W : `T_CALL_NI_REG_W;
				end
			end else if (ext == EXT_CALL_FAR) begin
				cls_nxt   = CALL_FAR_IND_OP;
				base_nxt  = narrow_bus ? `T_CALL_FI_N : `T_CALL_FI_W;
				unsup_nxt = !mem_opnd;
			end else if (ext == EXT_JMP_NEAR) begin
				cls_nxt = BRANCH_NEAR_IND_OP;
				if (!mem_opnd) begin
					base_nxt = `T_JMP_NI_REG;
				end else begin
					base_nxt = narrow_bus ? `T_JMP_NI_MEM_N : `T_JMP_NI_MEM_W;
				end
			end else if (ext == EXT_JMP_FAR) begin
				cls_nxt   = BRANCH_FAR_IND_OP;
				base_nxt  = narrow_bus ? `T_JMP_FI_N : `T_JMP_FI_W;
				unsup_nxt = !mem_opnd;
			end else begin
				unsup_nxt = 1'b1;
			end
		end else if (opcode_byte == PAT_JMP_SHORT) begin
			cls_nxt  = BRANCH_SHORT_OP;
			disp_nxt = 3'h1;
			base_nxt = `T_JMP_DIRECT;
		end else if (opcode_byte == PAT_JMP_NEAR) begin
			cls_nxt  = BRANCH_NEAR_OP;
			disp_nxt = 3'h2;
			base_nxt = `T_JMP_DIRECT;
		end else if (opcode_byte == PAT_JMP_FAR) begin
			cls_nxt  = BRANCH_FAR_OP;
			disp_nxt = 3'h4;
			base_nxt = `T_JMP_DIRECT;
		end else begin
			unsup_nxt = 1'b1;
		end
		// displacement bytes of a memory operand
		if (modrm_nxt && modrm_byte[`FLD_MOD_HI:`FLD_MOD_LO] == 2'h1) begin
			disp_nxt = 3'h1;
		end else if (modrm_nxt && (modrm_byte[`FLD_MOD_HI:`FLD_MOD_LO] == 2'h2 ||
			(modrm_byte[`FLD_MOD_HI:`FLD_MOD_LO] == 2'h0 &&
			modrm_byte[`FLD_RM_HI:`FLD_RM_LO] == 3'h6))) begin
			disp_nxt = 3'h2;
		end
		// word surcharge on the narrow bus for memory transfers
		if (star_word) begin
			if (cls_nxt == OP_XOR_RM || cls_nxt == OP_XOR_IMM_RM || cls_nxt == OP_INVERT) begin
				base_nxt = mem_opnd ? base_nxt + `T_WORD_EXTRA : base_nxt;
			end else if (rep_nxt) begin
				iter_nxt = iter_nxt + `T_WORD_EXTRA;
			end else if (cls_nxt != STRING_PORT_IN_OP && cls_nxt != STRING_PORT_OUT_OP &&
				(cls_nxt[9:5] != 5'h00)) begin
				base_nxt = base_nxt + `T_WORD_EXTRA;
			end
		end
		// a repeat prefix must match the string operation it guards
		if (prefix_valid && (!rep_seen || cls_nxt[11:5] == 7'h00 ||
			(rep_z_form && cls_nxt != STRING_COMPARE_OP && cls_nxt != STRING_SCAN_OP))) begin
			unsup_nxt = 1'b1;
		end
	end

	cycle_budget_calc #(
		.COUNT_W  (COUNT_W),
		.BUDGET_W (BUDGET_W)
	) u_budget (
		.base_cycles  (base_nxt),
		.iter_cycles  (iter_nxt),
		.iter_count   (count_register),
		.repeat_en    (rep_nxt),
		.total_cycles (budget_nxt)
	);

	// decode result valid one cycle after the request
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= instr_valid;
		end
	end

	// registered decode result, held until the next request
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			op_class        <= OP_NONE;
			word_op         <= 1'b0;
			reg_is_dest     <= 1'b0;
			repeat_active   <= 1'b0;
			repeat_on_equal <= 1'b0;
			modrm_used      <= 1'b0;
			imm_bytes       <= 3'h0;
			disp_bytes      <= 3'h0;
			cycle_budget    <= '0;
			unsupported     <= 1'b0;
		end else if (instr_valid) begin
			op_class        <= cls_nxt;
			word_op         <= w_bit;
			reg_is_dest     <= cls_nxt == OP_XOR_RM && opcode_byte[`FLD_D];
			repeat_active   <= rep_nxt;
			repeat_on_equal <= rep_nxt && prefix_byte[`FLD_Z];
			modrm_used      <= modrm_nxt;
			imm_bytes       <= imm_nxt;
			disp_bytes      <= disp_nxt;
			cycle_budget    <= budget_nxt;
			unsupported     <= unsup_nxt;
		end
	end

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	xor_acc_cost_a: assert property (instr_valid && opcode_byte == 8'h35 |=>
		op_class == OP_XOR_IMM_ACC && cycle_budget == 24'h000004 && imm_bytes == 3'h2)
		else $error("accumulator xor word cost wrong");
	invert_mem_cost_a: assert property (instr_valid && opcode_byte == 8'hF6 &&
		modrm_byte == 8'h16 |=> op_class == OP_INVERT && cycle_budget == 24'h00000A)
		else $error("invert memory byte cost wrong");
	move_single_cost_a: assert property (instr_valid && !prefix_valid &&
		opcode_byte == 8'hA5 && !narrow_bus |=> cycle_budget == 24'h00000E)
		else $error("single move cost wrong");
	compare_word_narrow_a: assert property (instr_valid && !prefix_valid &&
		opcode_byte == 8'hA7 && narrow_bus |=> cycle_budget == 24'h00001A)
		else $error("narrow word compare surcharge wrong");
	port_no_surcharge_a: assert property (instr_valid && !prefix_valid &&
		opcode_byte[7:1] == PAT_STR_IN |=> cycle_budget == 24'h00000E)
		else $error("port string cost wrong");
	rep_scan_cost_a: assert property (instr_valid && prefix_valid && prefix_byte == 8'hF3 &&
		opcode_byte == 8'hAE |=> repeat_on_equal && cycle_budget ==
		24'h000005 + 24'h00000F * BUDGET_W'($past(count_register)))
		else $error("repeated scan cost wrong");
	rep_move_cost_a: assert property (instr_valid && prefix_byte == 8'hF2 && prefix_valid &&
		opcode_byte == 8'hA4 |=> cycle_budget ==
		24'h000008 + 24'h000008 * BUDGET_W'($past(count_register)))
		else $error("repeated move cost wrong");
	rep_z_mismatch_a: assert property (instr_valid && prefix_valid && prefix_byte == 8'hF3 &&
		opcode_byte == 8'hA4 |=> unsupported)
		else $error("mismatched repeat prefix accepted");
	call_near_cost_a: assert property (instr_valid && opcode_byte == 8'hFF &&
		modrm_byte == 8'hD0 |=> op_class == CALL_NEAR_IND_OP &&
		cycle_budget == ($past(narrow_bus) ? 24'h000011 : 24'h00000D))
		else $error("near indirect call cost wrong");
	call_far_reg_a: assert property (instr_valid && opcode_byte == 8'hFF &&
		modrm_byte[7:3] == 5'h1B |=> op_class == CALL_FAR_IND_OP && unsupported)
		else $error("register far call not refused");
	jump_direct_a: assert property (instr_valid && opcode_byte == 8'hEA |=>
		op_class == BRANCH_FAR_OP && disp_bytes == 3'h4 && cycle_budget == 24'h00000E)
		else $error("far direct jump decode wrong");
	hold_result_a: assert property (dec_valid && !instr_valid |=> $stable(cycle_budget) &&
		$stable(word_op)) else $error("decode result not held");

endmodule : logic_string_branch_decode

// File: decode_timing_regs.svh
// timing counts and opcode field positions for the logic, string and branch decoder
`ifndef DECODE_TIMING_REGS_SVH
`define DECODE_TIMING_REGS_SVH

// opcode and mod/reg/rm field positions
`define FLD_W         0
`define FLD_D         1
`define FLD_Z         0
`define FLD_MOD_HI    7
`define FLD_MOD_LO    6
`define FLD_REG_HI    5
`define FLD_REG_LO    3
`define FLD_RM_HI     2
`define FLD_RM_LO     0

// clock counts, single operations
`define T_XOR_RM_REG      8'h03
`define T_XOR_RM_MEM      8'h0A
`define T_XOR_IMM_REG     8'h04
`define T_XOR_IMM_MEM     8'h10
`define T_XOR_ACC_BYTE    8'h03
`define T_XOR_ACC_WORD    8'h04
`define T_INV_REG         8'h03
`define T_INV_MEM         8'h0A
`define T_STR_MOVE        8'h0E
`define T_STR_CMP         8'h16
`define T_STR_SCAN        8'h0F
`define T_STR_LOAD        8'h0C
`define T_STR_STORE       8'h0A
`define T_STR_PORT        8'h0E
`define T_WORD_EXTRA      8'h04

// clock counts, repeated operations: base then per iteration
`define T_REP_MOVE_BASE   8'h08
`define T_REP_MOVE_ITER   8'h08
`define T_REP_CMP_BASE    8'h05
`define T_REP_CMP_ITER    8'h16
`define T_REP_SCAN_BASE   8'h05
`define T_REP_SCAN_ITER   8'h0F
`define T_REP_LOAD_BASE   8'h06
`define T_REP_LOAD_ITER   8'h0B
`define T_REP_STORE_BASE  8'h06
`define T_REP_STORE_ITER  8'h09

// clock counts, control transfer: wide bus then narrow bus
`define T_CALL_NI_REG_W   8'h0D
`define T_CALL_NI_MEM_W   8'h13
`define T_CALL_NI_REG_N   8'h11
`define T_CALL_NI_MEM_N   8'h1B
`define T_CALL_FI_W       8'h26
`define T_CALL_FI_N       8'h36
`define T_JMP_DIRECT      8'h0E
`define T_JMP_NI_REG      8'h0B
`define T_JMP_NI_MEM_W    8'h11
`define T_JMP_NI_MEM_N    8'h15
`define T_JMP_FI_W        8'h1A
`define T_JMP_FI_N        8'h22

`endif

// File: decode_pkg.sv
// types and opcode patterns for the logic, string and branch decoder
package decode_pkg;

	typedef enum logic [18:0] {
		OP_NONE            = 19'h00001,
		OP_XOR_RM          = 19'h00002,
		OP_XOR_IMM_RM      = 19'h00004,
		OP_XOR_IMM_ACC     = 19'h00008,
		OP_INVERT          = 19'h00010,
		STRING_MOVE_OP     = 19'h00020,
		STRING_COMPARE_OP  = 19'h00040,
		STRING_SCAN_OP     = 19'h00080,
		STRING_LOAD_OP     = 19'h00100,
		STRING_STORE_OP    = 19'h00200,
		STRING_PORT_IN_OP  = 19'h00400,
		STRING_PORT_OUT_OP = 19'h00800,
		CALL_NEAR_IND_OP   = 19'h01000,
		CALL_FAR_IND_OP    = 19'h02000,
		BRANCH_SHORT_OP    = 19'h04000,
		BRANCH_NEAR_OP     = 19'h08000,
		BRANCH_FAR_OP      = 19'h10000,
		BRANCH_NEAR_IND_OP = 19'h20000,
		BRANCH_FAR_IND_OP  = 19'h40000
	} op_class_t;

	localparam logic [5:0] PAT_XOR_RM      = 6'h0C;
	localparam logic [6:0] PAT_IMM_GROUP   = 7'h40;
	localparam logic [6:0] PAT_XOR_ACC     = 7'h1A;
	localparam logic [6:0] PAT_UNARY_GROUP = 7'h7B;
	localparam logic [6:0] PAT_STR_MOVE    = 7'h52;
	localparam logic [6:0] PAT_STR_CMP     = 7'h53;
	localparam logic [6:0] PAT_STR_SCAN    = 7'h57;
	localparam logic [6:0] PAT_STR_LOAD    = 7'h56;
	localparam logic [6:0] PAT_STR_STORE   = 7'h55;
	localparam logic [6:0] PAT_STR_IN      = 7'h36;
	localparam logic [6:0] PAT_STR_OUT     = 7'h37;
	localparam logic [6:0] PAT_REPEAT      = 7'h79;
	localparam logic [7:0] PAT_REPEAT_NZ   = 8'hF2;
	localparam logic [7:0] PAT_GROUP_FF    = 8'hFF;
	localparam logic [7:0] PAT_JMP_SHORT   = 8'hEB;
	localparam logic [7:0] PAT_JMP_NEAR    = 8'hE9;
	localparam logic [7:0] PAT_JMP_FAR     = 8'hEA;
	localparam logic [2:0] EXT_XOR         = 3'h6;
	localparam logic [2:0] EXT_INVERT      = 3'h2;
	localparam logic [2:0] EXT_CALL_NEAR   = 3'h2;
	localparam logic [2:0] EXT_CALL_FAR    = 3'h3;
	localparam logic [2:0] EXT_JMP_NEAR    = 3'h4;
	localparam logic [2:0] EXT_JMP_FAR     = 3'h5;

endpackage : decode_pkg

// File: cycle_budget_calc.sv
// clock budget arithmetic: base plus per-iteration cost times iteration count
`timescale 1ns/100ps
module cycle_budget_calc #(
	parameter int COUNT_W  = 16,
	parameter int BUDGET_W = 24
) (
	input  wire logic [7:0]          base_cycles,
	input  wire logic [7:0]          iter_cycles,
	input  wire logic [COUNT_W-1:0]  iter_count,
	input  wire logic                repeat_en,
	output logic      [BUDGET_W-1:0] total_cycles
);

	initial begin
		if (BUDGET_W < COUNT_W + 8) begin
			$error("budget width too small for count width");
		end
	end

	logic [BUDGET_W-1:0] product;

	// product fits: iter_cycles below 2^8, count below 2^COUNT_W
	always_comb begin
		product = BUDGET_W'(iter_cycles) * BUDGET_W'(iter_count);
		total_cycles = BUDGET_W'(base_cycles) + (repeat_en ? product : '0);
	end

endmodule : cycle_budget_calc

// File: fetch_source_model.sv
// instruction byte source standing on the fetch side of the decoder
`timescale 1ns/100ps
module fetch_source_model (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        req,
	input  wire logic        req_pre_v,
	input  wire logic [7:0]  req_pre,
	input  wire logic [7:0]  req_op,
	input  wire logic [7:0]  req_modrm,
	input  wire logic [15:0] req_count,
	output logic             instr_valid,
	output logic             prefix_valid,
	output logic [7:0]       prefix_byte,
	output logic [7:0]       opcode_byte,
	output logic [7:0]       modrm_byte,
	output logic [15:0]      count_register
);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			instr_valid    <= 1'b0;
			prefix_valid   <= 1'b0;
			prefix_byte    <= 8'h00;
			opcode_byte    <= 8'h00;
			modrm_byte     <= 8'h00;
			count_register <= 16'h0000;
		end else if (req) begin
			instr_valid    <= 1'b1;
			prefix_valid   <= req_pre_v;
			prefix_byte    <= req_pre;
			opcode_byte    <= req_op;
			modrm_byte     <= req_modrm;
			count_register <= req_count;
		end else begin
			// released bytes do not keep their last value
			instr_valid  <= 1'b0;
			prefix_valid <= 1'b0;
			prefix_byte  <= ~prefix_byte;
			opcode_byte  <= ~opcode_byte;
			modrm_byte   <= ~modrm_byte;
		end
	end
endmodule : fetch_source_model

// File: logic_string_branch_decode_tb_top.sv
// self-checking bench for the logic, string and branch decoder
`timescale 1ns/100ps
module logic_string_branch_decode_tb_top
	import decode_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        req = 1'b0;
	logic        pre_v = 1'b0;
	logic [7:0]  pre = 8'h00;
	logic [7:0]  op = 8'h00;
	logic [7:0]  mr = 8'h00;
	logic [15:0] cnt = 16'h0000;
	logic        narrow_bus = 1'b0;
	logic        instr_valid, prefix_valid, dec_valid, word_op, reg_is_dest;
	logic        repeat_active, repeat_on_equal, modrm_used, unsupported;
	logic [7:0]  prefix_byte, opcode_byte, modrm_byte;
	logic [15:0] count_register;
	logic [2:0]  imm_bytes, disp_bytes;
	logic [23:0] cycle_budget;
	op_class_t   op_class;
	int          err_total = 0;
	int          comparisons = 0;
	logic [7:0]  s_ops [7] = '{8'hA4, 8'hA6, 8'hAE, 8'hAC, 8'hAA, 8'h6C, 8'h6E};
	op_class_t   s_cls [7] = '{STRING_MOVE_OP, STRING_COMPARE_OP, STRING_SCAN_OP,
		STRING_LOAD_OP, STRING_STORE_OP, STRING_PORT_IN_OP, STRING_PORT_OUT_OP};

	always #4 clk_sys = ~clk_sys;

	fetch_source_model u_fetch_source_model (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
		.req_pre_v(pre_v), .req_pre(pre), .req_op(op), .req_modrm(mr), .req_count(cnt),
		.instr_valid(instr_valid), .prefix_valid(prefix_valid), .prefix_byte(prefix_byte),
		.opcode_byte(opcode_byte), .modrm_byte(modrm_byte), .count_register(count_register));

	logic_string_branch_decode u_logic_string_branch_decode (.clk_sys(clk_sys),
		.reset_n(reset_n), .instr_valid(instr_valid), .opcode_byte(opcode_byte),
		.modrm_byte(modrm_byte), .prefix_valid(prefix_valid), .prefix_byte(prefix_byte),
		.count_register(count_register), .narrow_bus(narrow_bus), .dec_valid(dec_valid),
		.op_class(op_class), .word_op(word_op), .reg_is_dest(reg_is_dest),
		.repeat_active(repeat_active), .repeat_on_equal(repeat_on_equal),
		.modrm_used(modrm_used), .imm_bytes(imm_bytes), .disp_bytes(disp_bytes),
		.cycle_budget(cycle_budget), .unsupported(unsupported));

	task automatic fail_msg(input string m);
		err_total++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail_msg

	task automatic cmp_class(input op_class_t g, input op_class_t e);
		comparisons++;
		if (g !== e) fail_msg($sformatf("class %h expected %h", g, e));
	endtask : cmp_class

	task automatic cmp_num(input logic [23:0] g, input logic [23:0] e, input string w);
		comparisons++;
		if (g !== e) fail_msg($sformatf("%s %0d expected %0d", w, g, e));
	endtask : cmp_num

	// one request, answer awaited under a bound; eb below zero skips the budget
	task automatic check(input logic [7:0] pb, input logic [7:0] o, input logic [7:0] m,
		input int n, input logic nb, input op_class_t ec, input int eb, input logic eu);
		int i;
		@(posedge clk_sys);
		req        <= 1'b1;
		pre_v      <= (pb != 8'h00);
		pre        <= pb;
		op         <= o;
		mr         <= m;
		cnt        <= 16'(n);
		narrow_bus <= nb;
		@(posedge clk_sys);
		req <= 1'b0;
		for (i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			#1;
			if (dec_valid === 1'b1) break;
		end
		cmp_num(24'(i), 24'h000000, "latency");
		cmp_class(op_class, ec);
		if (eb >= 0) cmp_num(cycle_budget, 24'(eb), "budget");
		cmp_num({23'h000000, unsupported}, {23'h000000, eu}, "unsupported");
		cmp_num({23'h000000, word_op}, {23'h000000, o[0]}, "width");
	endtask : check

	task automatic xor_forms();
		check(8'h00, 8'h33, 8'hC1, 0, 1'b0, OP_XOR_RM, 3, 1'b0);
		cmp_num({23'h000000, reg_is_dest}, 24'h000001, "dest");
		cmp_num({23'h000000, modrm_used}, 24'h000001, "modrm");
		check(8'h00, 8'h31, 8'h06, 0, 1'b1, OP_XOR_RM, 14, 1'b0);
		cmp_num({23'h000000, reg_is_dest}, 24'h000000, "dest");
		check(8'h00, 8'h31, 8'h06, 0, 1'b0, OP_XOR_RM, 10, 1'b0);
		cmp_num({21'h000000, disp_bytes}, 24'h000002, "disp");
		check(8'h00, 8'h81, 8'hF0, 0, 1'b0, OP_XOR_IMM_RM, 4, 1'b0);
		cmp_num({21'h000000, imm_bytes}, 24'h000002, "imm");
		check(8'h00, 8'h80, 8'h36, 0, 1'b1, OP_XOR_IMM_RM, 16, 1'b0);
		cmp_num({21'h000000, imm_bytes}, 24'h000001, "imm");
		check(8'h00, 8'h81, 8'h36, 0, 1'b1, OP_XOR_IMM_RM, 20, 1'b0);
		check(8'h00, 8'h81, 8'h0E, 0, 1'b0, OP_NONE, -1, 1'b1);
		check(8'h00, 8'h34, 8'h00, 0, 1'b1, OP_XOR_IMM_ACC, 3, 1'b0);
		check(8'h00, 8'h35, 8'h00, 0, 1'b1, OP_XOR_IMM_ACC, 4, 1'b0);
	endtask : xor_forms

	task automatic invert_forms();
		check(8'h00, 8'hF7, 8'hD0, 0, 1'b0, OP_INVERT, 3, 1'b0);
		check(8'h00, 8'hF6, 8'h16, 0, 1'b1, OP_INVERT, 10, 1'b0);
		check(8'h00, 8'hF7, 8'h16, 0, 1'b1, OP_INVERT, 14, 1'b0);
		check(8'h00, 8'hF7, 8'hD8, 0, 1'b0, OP_NONE, -1, 1'b1);
	endtask : invert_forms

	task automatic single_strings();
		int base [7] = '{14, 22, 15, 12, 10, 14, 14};
		int k;
		for (k = 0; k < 7; k++) begin
			check(8'h00, s_ops[k], 8'h00, 0, 1'b0, s_cls[k], base[k], 1'b0);
			check(8'h00, s_ops[k], 8'h00, 0, 1'b1, s_cls[k], base[k], 1'b0);
			check(8'h00, s_ops[k] | 8'h01, 8'h00, 0, 1'b1, s_cls[k],
				base[k] + (k < 5 ? 4 : 0), 1'b0);
		end
	endtask : single_strings

	task automatic repeat_strings();
		int         base [7] = '{8, 5, 5, 6, 6, 8, 8};
		int         iter [7] = '{8, 22, 15, 11, 9, 8, 8};
		logic [7:0] pfx [7] = '{8'hF2, 8'hF3, 8'hF2, 8'hF2, 8'hF2, 8'hF2, 8'hF2};
		int         k;
		for (k = 0; k < 7; k++) begin
			check(pfx[k], s_ops[k], 8'h00, 3, 1'b0, s_cls[k], base[k] + 3 * iter[k], 1'b0);
			cmp_num({23'h000000, repeat_active}, 24'h000001, "repeat");
			check(pfx[k], s_ops[k] | 8'h01, 8'h00, 5, 1'b1, s_cls[k],
				base[k] + 5 * (iter[k] + 4), 1'b0);
		end
		check(8'hF2, 8'hA4, 8'h00, 0, 1'b0, STRING_MOVE_OP, 8, 1'b0);
		check(8'hF3, 8'hAE, 8'h00, 2, 1'b0, STRING_SCAN_OP, 35, 1'b0);
		cmp_num({23'h000000, repeat_on_equal}, 24'h000001, "z bit");
		check(8'hF2, 8'hA6, 8'h00, 1, 1'b0, STRING_COMPARE_OP, 27, 1'b0);
		cmp_num({23'h000000, repeat_on_equal}, 24'h000000, "z bit");
		check(8'hF3, 8'hA4, 8'h00, 1, 1'b0, STRING_MOVE_OP, -1, 1'b1);
		check(8'hF2, 8'h31, 8'hC0, 1, 1'b0, OP_XOR_RM, -1, 1'b1);
	endtask : repeat_strings

	task automatic branch_forms();
		check(8'h00, 8'hFF, 8'hD0, 0, 1'b0, CALL_NEAR_IND_OP, 13, 1'b0);
		check(8'h00, 8'hFF, 8'h16, 0, 1'b0, CALL_NEAR_IND_OP, 19, 1'b0);
		check(8'h00, 8'hFF, 8'hD0, 0, 1'b1, CALL_NEAR_IND_OP, 17, 1'b0);
		check(8'h00, 8'hFF, 8'h16, 0, 1'b1, CALL_NEAR_IND_OP, 27, 1'b0);
		check(8'h00, 8'hFF, 8'h1E, 0, 1'b0, CALL_FAR_IND_OP, 38, 1'b0);
		check(8'h00, 8'hFF, 8'h1E, 0, 1'b1, CALL_FAR_IND_OP, 54, 1'b0);
		check(8'h00, 8'hFF, 8'hD8, 0, 1'b0, CALL_FAR_IND_OP, -1, 1'b1);
		check(8'h00, 8'hFF, 8'hE0, 0, 1'b0, BRANCH_NEAR_IND_OP, 11, 1'b0);
		check(8'h00, 8'hFF, 8'h26, 0, 1'b1, BRANCH_NEAR_IND_OP, 21, 1'b0);
		check(8'h00, 8'hFF, 8'h2E, 0, 1'b1, BRANCH_FAR_IND_OP, 34, 1'b0);
		check(8'h00, 8'hFF, 8'h26, 0, 1'b0, BRANCH_NEAR_IND_OP, 17, 1'b0);
		check(8'h00, 8'hFF, 8'h2E, 0, 1'b0, BRANCH_FAR_IND_OP, 26, 1'b0);
		check(8'h00, 8'hFF, 8'hE8, 0, 1'b0, BRANCH_FAR_IND_OP, -1, 1'b1);
		check(8'h00, 8'hFF, 8'h56, 0, 1'b0, CALL_NEAR_IND_OP, 19, 1'b0);
		cmp_num({21'h000000, disp_bytes}, 24'h000001, "disp");
		cmp_num({23'h000000, modrm_used}, 24'h000001, "modrm");
		check(8'h00, 8'hFF, 8'hF8, 0, 1'b0, OP_NONE, -1, 1'b1);
		check(8'h00, 8'hEB, 8'h00, 0, 1'b1, BRANCH_SHORT_OP, 14, 1'b0);
		cmp_num({21'h000000, disp_bytes}, 24'h000001, "disp");
		cmp_num({23'h000000, modrm_used}, 24'h000000, "modrm");
		check(8'h00, 8'hE9, 8'h00, 0, 1'b0, BRANCH_NEAR_OP, 14, 1'b0);
		cmp_num({21'h000000, disp_bytes}, 24'h000002, "disp");
		check(8'h00, 8'hEA, 8'h00, 0, 1'b1, BRANCH_FAR_OP, 14, 1'b0);
		cmp_num({21'h000000, disp_bytes}, 24'h000004, "disp");
	endtask : branch_forms

	task automatic back_to_back();
		@(posedge clk_sys);
		req        <= 1'b1;
		pre_v      <= 1'b0;
		op         <= 8'hA4;
		narrow_bus <= 1'b0;
		@(posedge clk_sys);
		op <= 8'hEB;
		@(posedge clk_sys);
		req <= 1'b0;
		#1;
		cmp_class(op_class, STRING_MOVE_OP);
		@(posedge clk_sys);
		#1;
		cmp_num({23'h000000, dec_valid}, 24'h000001, "second pulse");
		cmp_class(op_class, BRANCH_SHORT_OP);
		@(posedge clk_sys);
		#1;
		cmp_num({23'h000000, dec_valid}, 24'h000000, "pulse end");
		cmp_class(op_class, BRANCH_SHORT_OP);
	endtask : back_to_back

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		xor_forms();
		invert_forms();
		single_strings();
		repeat_strings();
		branch_forms();
		back_to_back();
		report_and_stop();
	end

	initial begin
		#(8 * 5000);
		fail_msg("watchdog expired");
		report_and_stop();
	end
endmodule : logic_string_branch_decode_tb_top
